/* hdl/srp_host.sv */
// design: host end of the serial rtc register port with an axi4-lite slave
`timescale 1ns/1ps
`default_nettype none
module srp_host (
   // clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // axi4-lite write address and data
   input  wire logic [3:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output wire logic        s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output wire logic        s_axi_wready,
   // axi4-lite write response
   output wire logic [1:0]  s_axi_bresp,
   output wire logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // axi4-lite read
   input  wire logic [3:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output wire logic        s_axi_arready,
   output wire logic [31:0] s_axi_rdata,
   output wire logic [1:0]  s_axi_rresp,
   output wire logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // serial link
   srp_link_if.host         link
);

   // link sequencer states, one-hot
   typedef enum logic [5:0] {
      HS_IDLE  = 6'h01, // no byte in progress
      HS_PREP  = 6'h02, // ce low, sclk at idle level
      HS_SETUP = 6'h04, // ce high before first edge
      HS_LEAD  = 6'h08, // sclk away from idle level
      HS_TRAIL = 6'h10, // sclk back at idle level
      HS_GAP   = 6'h20  // ce low after the frame
   } srp_hst_type;

   // all state of the host end
   typedef struct packed {
      logic        awready, wready, arready; // axi readies
      logic        aw_ok, w_ok;    // address or data held
      logic [3:0]  awa;            // held write address
      logic [31:0] wd;             // held write data
      logic [3:0]  ws;             // held write strobes
      logic        bvalid, rvalid; // axi answers
      logic [1:0]  bresp, rresp;   // axi answer codes
      logic [31:0] rdata;          // read data
      logic [1:0]  so_s;           // so synchroniser
      srp_hst_type st;             // sequencer state
      logic [7:0]  tx, rx, rxd;    // shift out, in, last byte in
      logic        last;           // close frame after this byte
      logic        idle_hi;        // sclk idle level of the frame
      logic [2:0]  cnt;            // bit count
      logic [15:0] tmr, div;       // half-period timer and setting
      logic        ce, sclk, si;   // link outputs
   } srp_host_state_type;

   // value after reset
   localparam srp_host_state_type HOST_RST = '{
      awready: 1'b1, wready: 1'b1, arready: 1'b1, st: HS_IDLE,
      div: srp_pkg::DIV_RST, default: '0};

   srp_host_state_type q;   // registered state
   srp_host_state_type nxt; // next state

   // true for an offset that the host map holds
   function automatic logic mapped(input logic [3:0] a);
      mapped = (a == srp_pkg::HOFF_XFER) || (a == srp_pkg::HOFF_RXD)
               || (a == srp_pkg::HOFF_STAT) || (a == srp_pkg::HOFF_DIV);
   endfunction

   logic tick; // half period over

   assign tick = (q.tmr == 16'h0000);

   // next-state logic
   always_comb begin
      nxt      = q;
      nxt.so_s = {q.so_s[0], link.so};
      nxt.tmr  = tick ? q.tmr : 16'(q.tmr - 16'h0001);
      // link sequencer, each step lasts div cycles
      case (q.st)
         HS_IDLE: begin
            nxt.st = HS_IDLE;
         end
         HS_PREP: begin
            if (tick) begin
               nxt.ce  = 1'b1;
               nxt.st  = HS_SETUP;
               nxt.tmr = 16'(q.div - 16'h0001);
            end
         end
         HS_SETUP, HS_TRAIL: begin
            if (tick && q.st == HS_TRAIL && q.cnt == srp_pkg::BIT_LAST) begin
               nxt.rxd = q.rx;
               nxt.cnt = 3'h0;
               if (q.last) begin
                  nxt.ce  = 1'b0;
                  nxt.st  = HS_GAP;
                  nxt.tmr = 16'(q.div - 16'h0001);
               end else begin
                  nxt.st = HS_IDLE;
               end
            end else if (tick) begin
               // leading edge: launch next bit msb first
               nxt.cnt  = (q.st == HS_TRAIL) ? 3'(q.cnt + 3'h1) : 3'h0;
               nxt.sclk = ~q.idle_hi;
               nxt.si   = q.tx[7];
               nxt.tx   = {q.tx[6:0], 1'b0};
               nxt.st   = HS_LEAD;
               nxt.tmr  = 16'(q.div - 16'h0001);
            end
         end
         HS_LEAD: begin
            if (tick) begin
               // trailing edge: sample so just before it
               nxt.sclk = q.idle_hi;
               nxt.rx   = {q.rx[6:0], q.so_s[1]};
               nxt.st   = HS_TRAIL;
               nxt.tmr  = 16'(q.div - 16'h0001);
            end
         end
         HS_GAP: begin
            if (tick) begin
               nxt.st = HS_IDLE;
            end
         end
         default: begin
            nxt.st = HS_IDLE;
         end
      endcase
      // axi write channels, taken in either order
      if (s_axi_awvalid && q.awready) begin
         nxt.aw_ok   = 1'b1;
         nxt.awa     = s_axi_awaddr;
         nxt.awready = 1'b0;
      end
      if (s_axi_wvalid && q.wready) begin
         nxt.w_ok   = 1'b1;
         nxt.wd     = s_axi_wdata;
         nxt.ws     = s_axi_wstrb;
         nxt.wready = 1'b0;
      end
      if (q.aw_ok && q.w_ok && !q.bvalid) begin
         nxt.aw_ok  = 1'b0;
         nxt.w_ok   = 1'b0;
         nxt.bvalid = 1'b1;
         nxt.bresp  = mapped(q.awa) ? srp_pkg::RESP_OKAY : srp_pkg::RESP_SLVERR;
         if (q.awa == srp_pkg::HOFF_XFER) begin
            // a new byte starts only when the sequencer is idle
            if (q.st == HS_IDLE && q.ws[0]) begin
               nxt.tx   = q.wd[7:0];
               nxt.last = q.ws[1] & q.wd[srp_pkg::XFER_LAST_BIT];
               nxt.tmr  = 16'(q.div - 16'h0001);
               if (!q.ce) begin
                  // open a frame: set idle level first, then raise ce
                  nxt.idle_hi = q.ws[1] & q.wd[srp_pkg::XFER_IDLE_BIT];
                  nxt.sclk    = q.ws[1] & q.wd[srp_pkg::XFER_IDLE_BIT];
                  nxt.st      = HS_PREP;
               end else begin
                  nxt.st = HS_SETUP;
               end
            end
         end else if (q.awa == srp_pkg::HOFF_DIV) begin
            if (q.ws[0]) begin
               nxt.div[7:0] = q.wd[7:0];
            end
            if (q.ws[1]) begin
               nxt.div[15:8] = q.wd[15:8];
            end
         end
      end
      if (q.bvalid && s_axi_bready) begin
         nxt.bvalid  = 1'b0;
         nxt.awready = 1'b1;
         nxt.wready  = 1'b1;
      end
      // axi read channel
      if (s_axi_arvalid && q.arready) begin
         nxt.arready = 1'b0;
         nxt.rvalid  = 1'b1;
         nxt.rresp   = mapped(s_axi_araddr) ? srp_pkg::RESP_OKAY : srp_pkg::RESP_SLVERR;
         if (s_axi_araddr == srp_pkg::HOFF_RXD) begin
            nxt.rdata = {24'h00_0000, q.rxd};
         end else if (s_axi_araddr == srp_pkg::HOFF_STAT) begin
            nxt.rdata = {29'h0000_0000, q.idle_hi, q.ce, q.st != HS_IDLE};
         end else if (s_axi_araddr == srp_pkg::HOFF_DIV) begin
            nxt.rdata = {16'h0000, q.div};
         end else begin
            nxt.rdata = 32'h0000_0000;
         end
      end
      if (q.rvalid && s_axi_rready) begin
         nxt.rvalid  = 1'b0;
         nxt.arready = 1'b1;
      end
   end

   // state register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= HOST_RST;
      end else begin
         q <= nxt;
      end
   end

   // outputs straight from the state register
   assign s_axi_awready = q.awready;
   assign s_axi_wready  = q.wready;
   assign s_axi_bresp   = q.bresp;
   assign s_axi_bvalid  = q.bvalid;
   assign s_axi_arready = q.arready;
   assign s_axi_rdata   = q.rdata;
   assign s_axi_rresp   = q.rresp;
   assign s_axi_rvalid  = q.rvalid;
   assign link.ce       = q.ce;
   assign link.sclk     = q.sclk;
   assign link.si       = q.si;

endmodule // srp_host
`default_nettype wire

/* hdl/srp_pkg.sv */
// package: shared constants for the serial rtc register port
package srp_pkg;
   // transfer format codes in the low command nibble
   localparam logic [3:0] FMT_WR_ONE   = 4'h8;
   localparam logic [3:0] FMT_WR_BURST = 4'h0;
   localparam logic [3:0] FMT_RD_ONE   = 4'hC;
   localparam logic [3:0] FMT_RD_BURST = 4'h4;
   // alarm register addresses in the device map
   localparam logic [3:0] ADDR_WK_MIN  = 4'h8;
   localparam logic [3:0] ADDR_WK_HOUR = 4'h9;
   localparam logic [3:0] ADDR_WK_DAYS = 4'hA;
   localparam logic [3:0] ADDR_DY_MIN  = 4'hB;
   localparam logic [3:0] ADDR_DY_HOUR = 4'hC;
   // implemented bits per register kind, unused bits read zero
   localparam logic [7:0] MASK_SEVEN = 8'h7F;
   localparam logic [7:0] MASK_HOUR  = 8'h3F;
   localparam logic [7:0] MASK_ALL   = 8'hFF;
   // day code with no enable bit behind it
   localparam logic [2:0] DAY_NONE = 3'h7;
   // index of the last bit of a byte
   localparam logic [2:0] BIT_LAST = 3'h7;
   // carry hold limit: 1 second at the system clock
   localparam int CLK_HZ   = 25_000_000;
   localparam int HOLD_MS  = 1000;
   localparam int HOLD_CYC = CLK_HZ / 1000 * HOLD_MS;
   // host register offsets
   localparam logic [3:0] HOFF_XFER = 4'h0;
   localparam logic [3:0] HOFF_RXD  = 4'h4;
   localparam logic [3:0] HOFF_STAT = 4'h8;
   localparam logic [3:0] HOFF_DIV  = 4'hC;
   // host transfer register fields
   localparam int XFER_LAST_BIT = 8;
   localparam int XFER_IDLE_BIT = 9;
   // host half-period divider after reset
   localparam logic [15:0] DIV_RST = 16'h0008;
   // axi response codes
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* hdl/srp_link_if.sv */
// interface: four-wire link between host end and device end
`timescale 1ns/1ps
`default_nettype none
interface srp_link_if;
   logic ce;    // chip enable, frames a transfer
   logic sclk;  // serial clock made by the host
   logic si;    // data from host to device
   logic so;    // data from device to host
   logic so_oe; // device drives so while high
   // device end
   modport device (input ce, input sclk, input si, output so, output so_oe);
   // host end
   modport host (output ce, output sclk, output si, input so, input so_oe);
endinterface // srp_link_if
`default_nettype wire

/* hdl/srp_device.sv */
// design: device end of the serial rtc register port with alarm registers
`timescale 1ns/1ps
`default_nettype none
module srp_device #(
   parameter int HOLD_CYCLES = srp_pkg::HOLD_CYC // carry hold limit in cycles
) (
   // clock and reset
   input  wire logic       aclk,
   input  wire logic       aresetn,
   // serial link
   srp_link_if.device      link,
   // current time from the timekeeping counters
   input  wire logic [2:0] cur_day,
   input  wire logic [5:0] cur_hour,
   input  wire logic [6:0] cur_min,
   // alarm matches and carry hold
   output wire logic       wk_match,
   output wire logic       dy_match,
   output wire logic       carry_hold
);

   // width of the carry hold counter
   localparam int HOLD_W = $clog2(HOLD_CYCLES + 1);

   // port states, one-hot
   typedef enum logic [3:0] {
      DS_IDLE = 4'h1, // ce low
      DS_CMD  = 4'h2, // shifting a command byte
      DS_WR   = 4'h4, // shifting write data in
      DS_RD   = 4'h8  // shifting read data out
   } srp_dst_type;

   // all state of the device end
   typedef struct packed {
      logic [1:0]       ce_s;       // ce synchroniser
      logic [1:0]       sclk_s;     // sclk synchroniser
      logic [1:0]       si_s;       // si synchroniser
      logic             sclk_d;     // synced sclk one cycle late
      logic             idle_hi;    // edge mode of this frame
      srp_dst_type      st;         // port state
      logic             burst;      // burst format selected
      logic [3:0]       addr;       // address pointer
      logic [2:0]       cnt;        // bit count in the byte
      logic [7:0]       rx;         // incoming shift register
      logic [7:0]       tx;         // outgoing shift register
      logic [15:0][7:0] regs;       // register file
      logic             so;         // serial output level
      logic             so_oe;      // serial output enable
      logic [HOLD_W-1:0] hold_cnt;  // cycles of ce high
      logic             carry_hold; // carries into seconds held
      logic             wk_match;   // weekday alarm match
      logic             dy_match;   // daily alarm match
   } srp_dev_state_type;

   // value after reset; register contents are cleared
   localparam srp_dev_state_type DEV_RST = '{st: DS_IDLE, default: '0};

   srp_dev_state_type q;   // registered state
   srp_dev_state_type nxt; // next state

   // implemented bits of an addressed register
   function automatic logic [7:0] wmask(input logic [3:0] a);
      if (a == srp_pkg::ADDR_WK_HOUR || a == srp_pkg::ADDR_DY_HOUR) begin
         wmask = srp_pkg::MASK_HOUR;
      end else if (a == srp_pkg::ADDR_WK_MIN || a == srp_pkg::ADDR_WK_DAYS
                   || a == srp_pkg::ADDR_DY_MIN) begin
         wmask = srp_pkg::MASK_SEVEN;
      end else begin
         wmask = srp_pkg::MASK_ALL;
      end
   endfunction

   logic       sck_rise; // synced sclk rising edge
   logic       sck_fall; // synced sclk falling edge
   logic       cap_edge; // edge that captures si
   logic       lau_edge; // edge that launches so
   logic [7:0] rx_byte;  // byte with the current si bit added
   logic       byte_end; // this capture completes a byte
   logic [3:0] addr_inc; // pointer plus one, wraps Fh to 0h

   // edge finding on the second synchroniser stage only
   assign sck_rise = q.sclk_s[1] & ~q.sclk_d;
   assign sck_fall = ~q.sclk_s[1] & q.sclk_d;
   assign cap_edge = q.idle_hi ? sck_rise : sck_fall;
   assign lau_edge = q.idle_hi ? sck_fall : sck_rise;
   assign rx_byte  = {q.rx[6:0], q.si_s[1]};
   assign byte_end = cap_edge && (q.cnt == srp_pkg::BIT_LAST);
   assign addr_inc = 4'(q.addr + 4'h1);

   // next-state logic
   always_comb begin
      nxt = q;
      // two-flop synchronisers on all link inputs
      nxt.ce_s   = {q.ce_s[0], link.ce};
      nxt.sclk_s = {q.sclk_s[0], link.sclk};
      nxt.si_s   = {q.si_s[0], link.si};
      nxt.sclk_d = q.sclk_s[1];
      // shift and count on every capture edge
      if (cap_edge) begin
         nxt.rx  = rx_byte;
         nxt.cnt = 3'(q.cnt + 3'h1);
      end
      if (!q.ce_s[1]) begin
         // ce low: drop any partial byte and release so
         nxt.st    = DS_IDLE;
         nxt.cnt   = 3'h0;
         nxt.so    = 1'b0;
         nxt.so_oe = 1'b0;
      end else begin
         case (q.st)
            DS_IDLE: begin
               // first cycle of ce high: sclk level picks edge mode
               nxt.idle_hi = q.sclk_s[1];
               nxt.cnt     = 3'h0;
               nxt.st      = DS_CMD;
            end
            DS_CMD: begin
               if (byte_end) begin
                  nxt.addr = rx_byte[7:4];
                  // low nibble picks the transfer format
                  case (rx_byte[3:0])
                     srp_pkg::FMT_WR_ONE: begin
                        nxt.st    = DS_WR;
                        nxt.burst = 1'b0;
                     end
                     srp_pkg::FMT_WR_BURST: begin
                        nxt.st    = DS_WR;
                        nxt.burst = 1'b1;
                     end
                     srp_pkg::FMT_RD_ONE: begin
                        nxt.st    = DS_RD;
                        nxt.burst = 1'b0;
                        nxt.tx    = q.regs[rx_byte[7:4]] & wmask(rx_byte[7:4]);
                     end
                     srp_pkg::FMT_RD_BURST: begin
                        nxt.st    = DS_RD;
                        nxt.burst = 1'b1;
                        nxt.tx    = q.regs[rx_byte[7:4]] & wmask(rx_byte[7:4]);
                     end
                     default: begin
                        // unknown format: wait for another command
                        nxt.st = DS_CMD;
                     end
                  endcase
               end
            end
            DS_WR: begin
               if (byte_end) begin
                  // store with unused bits forced to zero
                  nxt.regs[q.addr] = rx_byte & wmask(q.addr);
                  if (q.burst) begin
                     nxt.addr = addr_inc;
                  end else begin
                     nxt.st = DS_CMD;
                  end
               end
            end
            DS_RD: begin
               // launch edge drives the next bit, msb first
               if (lau_edge) begin
                  nxt.so    = q.tx[7];
                  nxt.so_oe = 1'b1;
                  nxt.tx    = {q.tx[6:0], 1'b0};
               end
               if (byte_end) begin
                  if (q.burst) begin
                     nxt.addr = addr_inc;
                     nxt.tx   = q.regs[addr_inc] & wmask(addr_inc);
                  end else begin
                     nxt.st    = DS_CMD;
                     nxt.so    = 1'b0;      // last bit must not linger
                     nxt.so_oe = 1'b0;
                  end
               end
            end
            default: begin
               nxt.st = DS_IDLE;
            end
         endcase
      end
      // carry hold while ce is high, released at ce fall or after limit
      if (q.ce_s[1]) begin
         if (q.carry_hold) begin
            nxt.hold_cnt = HOLD_W'(q.hold_cnt + 1'b1);
         end
         nxt.carry_hold = (q.hold_cnt < HOLD_W'(HOLD_CYCLES - 1));
      end else begin
         nxt.hold_cnt   = '0;
         nxt.carry_hold = 1'b0;
      end
      // alarm compare; bcd codes compared as stored, 12/32 included
      nxt.wk_match = (cur_day != srp_pkg::DAY_NONE)
                     && q.regs[srp_pkg::ADDR_WK_DAYS][cur_day]
                     && (q.regs[srp_pkg::ADDR_WK_HOUR][5:0] == cur_hour)
                     && (q.regs[srp_pkg::ADDR_WK_MIN][6:0] == cur_min);
      nxt.dy_match = (q.regs[srp_pkg::ADDR_DY_HOUR][5:0] == cur_hour)
                     && (q.regs[srp_pkg::ADDR_DY_MIN][6:0] == cur_min);
   end

   // state register; register file cleared, host must reprogram
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= DEV_RST;
      end else begin
         q <= nxt;
      end
   end

   // outputs straight from the state register
   assign link.so    = q.so;
   assign link.so_oe = q.so_oe;
   assign wk_match   = q.wk_match;
   assign dy_match   = q.dy_match;
   assign carry_hold = q.carry_hold;

endmodule // srp_device
`default_nettype wire

/* bench/srp_props.sv */
// checker: link rules watched on the four wires between both ends
`timescale 1ns/1ps
`default_nettype none
module srp_props (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // link wires
   input wire logic ce,
   input wire logic sclk,
   input wire logic si,
   input wire logic so,
   input wire logic so_oe
);
   logic       ce_r;   // ce one cycle ago
   logic       sclk_r; // sclk one cycle ago
   logic       mode_r; // idle level latched at frame start
   logic [2:0] cnt_r;  // capture edges within the current byte
   logic       cap;    // trailing edge, sclk back at idle level
   assign cap = ce && (sclk != sclk_r) && (sclk == mode_r);
   // track frame start, edge mode and bit count
   always_ff @(posedge aclk) begin
      ce_r <= ce;
      sclk_r <= sclk;
      if (!aresetn) begin
         mode_r <= 1'b0;
      end else if (ce && !ce_r) begin
         mode_r <= sclk;
      end
      if (!aresetn || !ce) begin
         cnt_r <= 3'h0;
      end else if (cap) begin
         cnt_r <= cnt_r + 3'h1;
      end
   end
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   AST_MODE_HOLD: assert property ($rose(ce) |-> $stable(sclk))
      else $error("sclk moved as ce rose");
   AST_HALF_PERIOD: assert property (ce && $changed(sclk) |=> $stable(sclk) [*7])
      else $error("sclk half period too short");
   AST_SI_AT_CAPTURE: assert property (cap |-> $stable(si))
      else $error("si moved on capture edge");
   AST_SO_AT_CAPTURE: assert property (so_oe && cap |-> $stable(so) ##1 $stable(so))
      else $error("so moved at capture edge");
   AST_CE_FALL_IDLE: assert property ($fell(ce) |-> sclk == mode_r)
      else $error("ce fell with sclk off idle");
   AST_WHOLE_BYTES: assert property ($fell(ce) |-> cnt_r == 3'h0)
      else $error("frame ended mid byte");
   AST_SO_QUIET: assert property (!so_oe |-> !so)
      else $error("so high while undriven");
   AST_OE_OUT_FRAME: assert property (!ce [*5] |-> !so_oe)
      else $error("so driven outside frame");
   AST_OE_START: assert property ($rose(so_oe) |-> ce)
      else $error("so driven before frame");
   // main scenarios reached
   cover property ($rose(so_oe));
   cover property ($fell(ce) && mode_r);
   cover property (cap && cnt_r == 3'h7);
endmodule // srp_props
`default_nettype wire

/* bench/tb_top.sv */
// testbench: host and device ends joined, driven over axi4-lite
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic [3:0]  awaddr, araddr, wstrb;
   logic [31:0] wdata, rdata, rd_v;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp, rsp;
   logic [2:0]  cur_day;
   logic [5:0]  cur_hour;
   logic [6:0]  cur_min;
   logic        wk_match, dy_match, carry_hold;
   int          miscompares, num_checks;
   srp_link_if link ();
   srp_host i_srp_host (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .link(link.host));
   // short carry hold so its limit is reached in the run
   srp_device #(.HOLD_CYCLES(400)) i_srp_device (.aclk(aclk), .aresetn(aresetn),
      .link(link.device), .cur_day(cur_day), .cur_hour(cur_hour), .cur_min(cur_min),
      .wk_match(wk_match), .dy_match(dy_match), .carry_hold(carry_hold));
   srp_props i_srp_props (.aclk(aclk), .aresetn(aresetn), .ce(link.ce),
      .sclk(link.sclk), .si(link.si), .so(link.so), .so_oe(link.so_oe));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic close_out;
      if (miscompares == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // write one word, hold each channel until taken, wait for the response
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
      rsp = bresp;
      @(posedge aclk);
   endtask
   // read one word into rd_v and rsp
   task automatic axi_rd(input logic [3:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      rready <= 1'b0;
      rd_v = rdata;
      rsp = rresp;
      @(posedge aclk);
   endtask
   // move one byte over the link and wait until the host is idle
   task automatic xfer(input logic [7:0] b, input logic last, input logic idle);
      axi_wr(srp_pkg::HOFF_XFER, {22'h0, idle, last, b});
      check(rsp, srp_pkg::RESP_OKAY);
      do axi_rd(srp_pkg::HOFF_STAT);
      while (rd_v[0] !== 1'b0);
   endtask
   task automatic t_single;
      xfer(8'hB8, 1'b0, 1'b0);
      check(carry_hold, 1'b1);
      repeat (450) @(posedge aclk);
      check(carry_hold, 1'b0);
      xfer(8'h45, 1'b1, 1'b0);
      xfer(8'hBC, 1'b0, 1'b0);
      xfer(8'h00, 1'b1, 1'b0);
      axi_rd(srp_pkg::HOFF_RXD);
      check(rd_v, 32'h0000_0045);
      xfer(8'hBC, 1'b0, 1'b1);
      xfer(8'h00, 1'b1, 1'b1);
      axi_rd(srp_pkg::HOFF_RXD);
      check(rd_v, 32'h0000_0045);
      xfer(8'hC8, 1'b0, 1'b0);
      xfer(8'hFF, 1'b0, 1'b0);
      xfer(8'hCC, 1'b0, 1'b0);
      xfer(8'h00, 1'b1, 1'b0);
      axi_rd(srp_pkg::HOFF_RXD);
      check(rd_v, 32'h0000_003F);
      // unknown format code: device waits for the next command byte
      xfer(8'hB1, 1'b0, 1'b0);
      xfer(8'hBC, 1'b0, 1'b0);
      xfer(8'h00, 1'b1, 1'b0);
      axi_rd(srp_pkg::HOFF_RXD);
      check(rd_v, 32'h0000_0045);
   endtask
   // burst write from Fh wraps to 0h and ends at Ah, burst read follows the same path
   task automatic t_burst;
      xfer(8'hF0, 1'b0, 1'b0);
      for (int i = 0; i < 12; i++) xfer((i == 11) ? 8'h95 : 8'h00, i == 11, 1'b0);
      xfer(8'hF4, 1'b0, 1'b0);
      for (int i = 0; i < 12; i++) xfer(8'h00, i == 11, 1'b0);
      axi_rd(srp_pkg::HOFF_RXD);
      check(rd_v, 32'h0000_0015);
   endtask
   task automatic t_alarm;
      logic [7:0] al [5] = '{8'h30, 8'h21, 8'h02, 8'h30, 8'h21};
      xfer(8'h80, 1'b0, 1'b0);
      for (int i = 0; i < 5; i++) xfer(al[i], i == 4, 1'b0);
      cur_hour <= 6'h21;
      cur_min <= 7'h30;
      cur_day <= 3'h1;
      repeat (3) @(posedge aclk);
      check(dy_match, 1'b1);
      check(wk_match, 1'b1);
      cur_day <= 3'h0;
      repeat (3) @(posedge aclk);
      check(wk_match, 1'b0);
      cur_min <= 7'h31;
      repeat (3) @(posedge aclk);
      check(dy_match, 1'b0);
      xfer(8'hA8, 1'b0, 1'b0);
      xfer(8'h00, 1'b1, 1'b0);
      cur_day <= 3'h1;
      cur_min <= 7'h30;
      repeat (3) @(posedge aclk);
      check(wk_match, 1'b0);
   endtask
   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
      {awaddr, araddr, wdata, cur_day, cur_hour, cur_min} = '0;
      wstrb = 4'hF;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      axi_rd(srp_pkg::HOFF_DIV);
      check(rd_v, {16'h0000, srp_pkg::DIV_RST});
      axi_rd(4'h2);
      check(rsp, srp_pkg::RESP_SLVERR);
      t_single;
      t_burst;
      t_alarm;
      close_out;
   end
   // watchdog cuts a hang short
   initial begin
      repeat (60000) @(posedge aclk);
      miscompares++;
      close_out;
   end
endmodule // tb_top
`default_nettype wire
